// file: pssr_pkg.sv
package pssr_pkg;

  // ==========================================================
  // phy control register port
  localparam logic [15:0] PHY_RX_OVERRIDE_CONTROL_ADDR = 16'h1005;
  localparam logic [15:0] PHY_RX_STATUS_ADDR           = 16'h100d;
  localparam logic [15:0] RX_DISABLE_DATA              = 16'h0028;
  localparam logic [15:0] RX_ENABLE_DATA               = 16'h0000;
  localparam logic [15:0] RX_VALID_MASK                = 16'h0001;

  // ==========================================================
  // timing
  localparam int          CLK_PERIOD_PS  = 5000;
  localparam int          CHECK_WAIT_MS  = 2;
  localparam int          CHECK_WAIT_CYC = CHECK_WAIT_MS * 1000000000 / CLK_PERIOD_PS;
  localparam int          MIN_TS2_COUNT  = 32;
  localparam logic [7:0]  LP_ENTRY_MAX   = 8'hff;
  localparam int          PWR_ACK_TIMEOUT_CYC = 4800000;

  // ==========================================================
  // link states seen by the sequencer
  localparam logic [4:0]  LTSSM_L0        = 5'h11;
  localparam logic [4:0]  LTSSM_RCVR_LOCK = 5'h0d;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pssr_phy_control_register_port_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } pssr_phy_control_register_port_rsp_t;

  typedef enum logic [1:0] {
    SEQ_NONE,
    SEQ_COLD,
    SEQ_L2_ENTER,
    SEQ_L2_EXIT
  } pssr_seq_t;

endpackage

// file: pssr_seq.sv
`timescale 1ns/10ps
// How it works
// - replay wrap 11b to 00b: retrain, hold replay
// - fifo read pointer waits for write clock
// - send at least 32 TS2 before speed
// - wait programmed cycles before low power
// - capture phystatus on L1 exit
// - power ack timeout goes to detect
// - autonomous speed disable bit is sticky
module pssr_seq
  import pssr_pkg::*;
#(
  parameter int CHECK_WAIT   = pssr_pkg::CHECK_WAIT_CYC,
  parameter int PWR_ACK_WAIT = pssr_pkg::PWR_ACK_TIMEOUT_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   link_down_reset,
  input  wire logic                   start_cold,
  input  wire logic                   start_l2_enter,
  input  wire logic                   start_l2_exit,
  input  wire logic                   partner_gen2,
  input  wire logic [4:0]             ltssm_state,
  output pssr_pkg::pssr_phy_control_register_port_req_t    phy_control_register_port,
  input  wire pssr_pkg::pssr_phy_control_register_port_rsp_t phy_phy_control_register_port_rsp,
  output logic                        ltssm_enable,
  output logic                        gen2_support,
  output logic                        directed_speed_change_bit,
  input  wire logic [1:0]             replay_num,
  input  wire logic                   replay_start,
  output logic                        retrain_req,
  output logic                        replay_hold,
  input  wire logic                   retrain_done,
  input  wire logic                   wr_clk_seen,
  output logic                        fifo_rd_enable,
  input  wire logic                   in_rcvr_cfg,
  input  wire logic                   ts2_sent,
  output logic                        speed_ok,
  input  wire logic                   pm_cfg_write,
  input  wire logic [7:0]             lp_entry_count,
  output logic                        lp_entry_go,
  input  wire logic                   p0_requested,
  input  wire logic                   phystatus,
  output logic                        phystatus_seen,
  output logic                        pwr_timeout_detect,
  input  wire logic                   asd_wr,
  input  wire logic                   asd_wdata,
  output logic                        asd_bit,
  output logic                        seq_busy,
  output logic                        seq_done,
  output logic                        seq_error,
  output logic [7:0]                  rx_reset_count
);
  import pssr_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_OFF, S_GEN2_OFF, S_ON, S_WAIT_L0, S_REQ_GEN2,
    S_WAIT2MS, S_RD_VALID, S_RST_DIS, S_RST_EN, S_FINISH
  } pssr_state_t;

  pssr_state_t state_reg;
  pssr_seq_t   kind_reg;
  logic [31:0] wait_reg;
  logic [1:0]  replay_prev_reg;
  logic [5:0]  ts2_cnt_reg;
  logic [7:0]  lp_cnt_reg;
  logic        lp_run_reg;
  logic [31:0] pwr_cnt_reg;
  logic        stuck;

  // ==========================================================
  // sequencer
  assign stuck = (ltssm_state == LTSSM_RCVR_LOCK);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg      <= S_IDLE;
      kind_reg       <= SEQ_NONE;
      wait_reg       <= '0;
      ltssm_enable   <= 1'b1;
      gen2_support   <= 1'b1;
      directed_speed_change_bit <= 1'b0;
      phy_control_register_port <= '0;
      seq_done       <= 1'b0;
      seq_error      <= 1'b0;
      rx_reset_count <= '0;
    end else begin
      seq_done  <= 1'b0;
      seq_error <= 1'b0;
      unique case (state_reg)
        S_IDLE: begin
          if (start_cold) begin
            kind_reg  <= SEQ_COLD;
            state_reg <= S_OFF;
          end else if (start_l2_enter) begin
            kind_reg  <= SEQ_L2_ENTER;
            wait_reg  <= 32'(CHECK_WAIT);
            state_reg <= S_WAIT2MS;
          end else if (start_l2_exit) begin
            kind_reg  <= SEQ_L2_EXIT;
            state_reg <= S_GEN2_OFF;
          end
        end
        S_OFF: begin
          ltssm_enable <= 1'b0;
          state_reg    <= S_GEN2_OFF;
        end
        S_GEN2_OFF: begin
          gen2_support <= 1'b0;
          state_reg    <= S_ON;
        end
        S_ON: begin
          ltssm_enable <= 1'b1;
          state_reg    <= S_WAIT_L0;
        end
        S_WAIT_L0: begin
          if (ltssm_state == LTSSM_L0) begin
            if (kind_reg == SEQ_L2_EXIT) begin
              kind_reg  <= SEQ_COLD;
              state_reg <= S_OFF;
            end else if (partner_gen2) begin
              state_reg <= S_REQ_GEN2;
            end else begin
              state_reg <= S_FINISH;
            end
          end
        end
        S_REQ_GEN2: begin
          gen2_support <= 1'b1;
          directed_speed_change_bit <= 1'b1;
          wait_reg  <= 32'(CHECK_WAIT);
          state_reg <= S_WAIT2MS;
        end
        S_WAIT2MS: begin
          directed_speed_change_bit <= 1'b0;
          if (wait_reg > 32'd1) begin
            wait_reg <= wait_reg - 32'd1;
          end else if (stuck) begin
            phy_control_register_port <= '{req: 1'b1, write: 1'b0,
                                           addr: PHY_RX_STATUS_ADDR, wdata: '0};
            state_reg <= S_RD_VALID;
          end else begin
            state_reg <= S_FINISH;
          end
        end
        S_RD_VALID: begin
          if (phy_phy_control_register_port_rsp.ack) begin
            if ((phy_phy_control_register_port_rsp.rdata & RX_VALID_MASK) == 16'h0000) begin
              phy_control_register_port <= '{req: 1'b1, write: 1'b1,
                addr: PHY_RX_OVERRIDE_CONTROL_ADDR, wdata: RX_DISABLE_DATA};
              state_reg <= S_RST_DIS;
            end else begin
              phy_control_register_port <= '0;
              state_reg <= S_FINISH;
            end
          end
        end
        S_RST_DIS: begin
          if (phy_phy_control_register_port_rsp.ack) begin
            phy_control_register_port <= '{req: 1'b1, write: 1'b1,
              addr: PHY_RX_OVERRIDE_CONTROL_ADDR, wdata: RX_ENABLE_DATA};
            state_reg <= S_RST_EN;
          end
        end
        S_RST_EN: begin
          if (phy_phy_control_register_port_rsp.ack) begin
            phy_control_register_port <= '0;
            rx_reset_count <= rx_reset_count + 8'h01;
            seq_error <= 1'b1;
            state_reg <= S_IDLE;
            kind_reg  <= SEQ_NONE;
          end
        end
        S_FINISH: begin
          seq_done  <= 1'b1;
          kind_reg  <= SEQ_NONE;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign seq_busy = (state_reg != S_IDLE);

  // ==========================================================
  // replay rollover: retrain before replaying
  always_ff @(posedge core_clk) begin
    if (reset) begin
      replay_prev_reg <= '0;
      retrain_req     <= 1'b0;
      replay_hold     <= 1'b0;
    end else begin
      replay_prev_reg <= replay_num;
      retrain_req     <= 1'b0;
      if (replay_prev_reg == 2'b11 && replay_num == 2'b00) begin
        retrain_req <= 1'b1;
        replay_hold <= 1'b1;
      end else if (retrain_done) begin
        replay_hold <= 1'b0;
      end
    end
  end

  // ==========================================================
  // fifo read pointer start gate
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fifo_rd_enable <= 1'b0;
    end else if (wr_clk_seen) begin
      fifo_rd_enable <= 1'b1;
    end
  end

  // ==========================================================
  // ts2 minimum in rcvr cfg
  always_ff @(posedge core_clk) begin
    if (reset || !in_rcvr_cfg) begin
      ts2_cnt_reg <= '0;
    end else if (ts2_sent && ts2_cnt_reg != 6'(MIN_TS2_COUNT)) begin
      ts2_cnt_reg <= ts2_cnt_reg + 6'd1;
    end
  end
  assign speed_ok = (ts2_cnt_reg == 6'(MIN_TS2_COUNT));

  // ==========================================================
  // low power entry delay
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lp_cnt_reg  <= '0;
      lp_run_reg  <= 1'b0;
      lp_entry_go <= 1'b0;
    end else begin
      lp_entry_go <= 1'b0;
      if (pm_cfg_write) begin
        lp_cnt_reg <= lp_entry_count;
        lp_run_reg <= 1'b1;
      end else if (lp_run_reg) begin
        if (lp_cnt_reg == 8'h00) begin
          lp_run_reg  <= 1'b0;
          lp_entry_go <= 1'b1;
        end else begin
          lp_cnt_reg <= lp_cnt_reg - 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // phystatus capture and power ack timeout
  // phystatus is latched sticky while p0_requested stays high, so a late pulse is never missed
  always_ff @(posedge core_clk) begin
    if (reset || !p0_requested) begin
      phystatus_seen     <= 1'b0;
      pwr_cnt_reg        <= '0;
      pwr_timeout_detect <= 1'b0;
    end else begin
      if (phystatus) begin
        phystatus_seen <= 1'b1;
      end
      if (!phystatus_seen && !phystatus) begin
        if (pwr_cnt_reg == 32'(PWR_ACK_WAIT)) begin
          pwr_timeout_detect <= 1'b1;
        end else begin
          pwr_cnt_reg <= pwr_cnt_reg + 32'd1;
        end
      end
    end
  end

  // ==========================================================
  // sticky autonomous speed disable: link_down_reset ignored
  always_ff @(posedge core_clk) begin
    if (reset) begin
      asd_bit <= 1'b0;
    end else if (asd_wr) begin
      asd_bit <= asd_wdata;
    end
  end

  chk_lp_delay_len: assert property (@(posedge core_clk) disable iff (reset)
    pm_cfg_write && lp_entry_count == 8'h02 ##1 !pm_cfg_write [*3] |=> lp_entry_go)
    else $error("low power entry delay wrong");
  chk_rollover_retrain: assert property (@(posedge core_clk) disable iff (reset)
    ($past(replay_num) == 2'b11 && replay_num == 2'b00) |=> retrain_req && replay_hold)
    else $error("rollover did not retrain");
  chk_fifo_gate: assert property (@(posedge core_clk) disable iff (reset)
    fifo_rd_enable |-> $past(wr_clk_seen) || $past(fifo_rd_enable))
    else $error("read pointer before write clock");
  chk_ts2_min: assert property (@(posedge core_clk) disable iff (reset)
    $rose(speed_ok) |-> in_rcvr_cfg)
    else $error("speed before ts2 count");
  chk_phystatus_hold: assert property (@(posedge core_clk) disable iff (reset)
    p0_requested && phystatus ##1 p0_requested |-> phystatus_seen)
    else $error("phystatus lost");
  chk_timeout_cause: assert property (@(posedge core_clk) disable iff (reset)
    pwr_timeout_detect |-> !phystatus_seen)
    else $error("timeout despite ack");
  chk_asd_sticky: assert property (@(posedge core_clk) disable iff (reset)
    link_down_reset && !asd_wr |=> asd_bit == $past(asd_bit))
    else $error("speed disable bit lost");
  chk_rx_reset_pair: assert property (@(posedge core_clk) disable iff (reset)
    state_reg == S_RST_DIS && phy_phy_control_register_port_rsp.ack |=>
      phy_control_register_port.wdata == RX_ENABLE_DATA && phy_control_register_port.write)
    else $error("rx reset second write wrong");

endmodule

// file: pssr_phy_model.sv
`timescale 1ns/10ps
// ==========================================
// phy and remote partner stand-in
module pssr_phy_model
  import pssr_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               ltssm_enable,
  input  wire logic               dsc,
  input  wire logic               gen2,
  input  wire logic               stuck,
  input  wire logic [1:0]         lat,
  input  wire pssr_pkg::pssr_phy_control_register_port_req_t phy_control_register_port_req,
  output pssr_pkg::pssr_phy_control_register_port_rsp_t      phy_control_register_port_rsp,
  output logic [4:0]              ltssm_state,
  output logic [31:0]             wr_log,
  output logic [7:0]              n_wr,
  output logic [7:0]              n_rd
);
  logic [2:0]  en_cnt_reg;
  logic        dsc_seen_reg;
  logic [1:0]  wait_reg;
  logic        ack_reg;
  logic [15:0] data_reg;
  always_ff @(posedge core_clk) begin
    if (reset || !ltssm_enable) begin
      en_cnt_reg   <= 3'h0;
      dsc_seen_reg <= 1'b0;
    end else begin
      if (en_cnt_reg != 3'h7) en_cnt_reg <= en_cnt_reg + 3'h1;
      // dropping gen2 support abandons a pending speed change
      if (!gen2) dsc_seen_reg <= 1'b0;
      else if (dsc) dsc_seen_reg <= 1'b1;
    end
  end
  // lock only sticks once a speed change was asked for
  assign ltssm_state = (en_cnt_reg != 3'h7) ? 5'h01 : (stuck && dsc_seen_reg) ? LTSSM_RCVR_LOCK : LTSSM_L0;
  always_ff @(posedge core_clk) begin
    ack_reg <= 1'b0;
    if (reset) begin
      wait_reg <= 2'h0;
      n_wr     <= 8'h0;
      n_rd     <= 8'h0;
      wr_log   <= 32'h0;
      data_reg <= 16'h0;
    end else if (phy_control_register_port_req.req && !ack_reg) begin
      if (wait_reg < lat) wait_reg <= wait_reg + 2'h1;
      else begin
        wait_reg <= 2'h0;
        ack_reg  <= 1'b1;
        if (phy_control_register_port_req.write && phy_control_register_port_req.addr == PHY_RX_OVERRIDE_CONTROL_ADDR) begin
          wr_log <= {wr_log[15:0], phy_control_register_port_req.wdata};
          n_wr   <= n_wr + 8'h1;
        end
        if (!phy_control_register_port_req.write && phy_control_register_port_req.addr == PHY_RX_STATUS_ADDR) begin
          n_rd     <= n_rd + 8'h1;
          data_reg <= {15'h2d2d, !stuck};
        end
      end
    end
  end
  // released data shows the inverse, never a stale copy
  assign phy_control_register_port_rsp = '{ack: ack_reg, rdata: ack_reg ? data_reg : ~data_reg};
endmodule

// file: pcie_speed_change_recovery_seq_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm,e,g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module pcie_speed_change_recovery_seq_tb_top;
  import pssr_pkg::*;
  logic core_clk = 0, reset = 1, link_down_reset = 0, start_cold = 0, start_l2_enter = 0, start_l2_exit = 0;
  logic partner_gen2 = 1, replay_start = 0, retrain_done = 0, wr_clk_seen = 0, in_rcvr_cfg = 0, ts2_sent = 0;
  logic pm_cfg_write = 0, p0_requested = 0, phystatus = 0, asd_wr = 0, asd_wdata = 0, stuck = 0;
  logic [1:0] replay_num = 0, lat = 0;
  logic [7:0] lp_entry_count = 0, rx_reset_count, n_wr, n_rd, c0, w0, r0;
  logic [4:0] ltssm_state;
  logic [31:0] wr_log, seed = 32'd76;
  pssr_phy_control_register_port_req_t phy_control_register_port;
  pssr_phy_control_register_port_rsp_t phy_phy_control_register_port_rsp;
  logic ltssm_enable, gen2_support, directed_speed_change_bit, retrain_req, replay_hold, fifo_rd_enable, speed_ok;
  logic lp_entry_go, phystatus_seen, pwr_timeout_detect, asd_bit, seq_busy, seq_done, seq_error;
  int mismatches = 0, checks_done = 0, cyc = 0, err_n = 0, dsc_n = 0, rq_n = 0, done_n = 0, i, k, n;
  pssr_seq #(.CHECK_WAIT(10), .PWR_ACK_WAIT(20)) pssr_seq_inst (.*);
  pssr_phy_model pssr_phy_model_inst (.core_clk(core_clk), .reset(reset), .ltssm_enable(ltssm_enable),
    .dsc(directed_speed_change_bit), .gen2(gen2_support), .stuck(stuck), .lat(lat),
    .phy_control_register_port_req(phy_control_register_port),
    .phy_control_register_port_rsp(phy_phy_control_register_port_rsp), .ltssm_state(ltssm_state), .wr_log(wr_log), .n_wr(n_wr), .n_rd(n_rd));
  initial forever #2.5 core_clk = ~core_clk;
  // pulses counted mid-cycle, clear of the edge that launches them
  always @(negedge core_clk) begin
    cyc++;
    err_n += int'(seq_error === 1'b1);
    done_n += int'(seq_done === 1'b1);
    dsc_n += int'(directed_speed_change_bit === 1'b1);
    rq_n  += int'(retrain_req === 1'b1);
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int lp_expect(int cnt);
    // one edge loads the count, one more registers the go pulse
    return cnt + 2;
  endfunction
  task automatic step(int c);
    repeat (c) @(negedge core_clk);
  endtask
  task automatic run(int s);
    int j;
    @(negedge core_clk);
    start_cold = (s == 0);
    start_l2_enter = (s == 1);
    start_l2_exit = (s == 2);
    @(negedge core_clk);
    {start_cold, start_l2_enter, start_l2_exit} = 3'h0;
    for (j = 0; j < 400 && seq_busy !== 1'b0; j++) @(negedge core_clk);
  endtask
  task automatic close_out();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    step(3);
    reset = 0;
    step(1);
    `CHK("dsc_reset", 1'b0, directed_speed_change_bit)
    `CHK("rd_en_early", 1'b0, fifo_rd_enable)
    wr_clk_seen = 1;
    step(3);
    wr_clk_seen = 0;
    step(2);
    `CHK("rd_en_held", 1'b1, fifo_rd_enable)
    for (i = 0; i < 5; i++) begin
      stuck = i[0];
      lat = 2'(rnd());
      {c0, w0, r0} = {rx_reset_count, n_wr, n_rd};
      k = dsc_n;
      run(0);
      `CHK("cold_rst", 8'(c0 + stuck), rx_reset_count)
      `CHK("cold_wr", 8'(w0 + 2 * stuck), n_wr)
      `CHK("cold_rd", 8'(r0 + stuck), n_rd)
      `CHK("cold_dsc", k + 1, dsc_n)
      `CHK("cold_sup", 1'b1, gen2_support)
      `CHK("cold_on", 1'b1, ltssm_enable)
      if (stuck) `CHK("wr_order", {RX_DISABLE_DATA, RX_ENABLE_DATA}, wr_log)
    end
    stuck = 1;
    c0 = rx_reset_count;
    run(1);
    `CHK("l2_stuck", 8'(c0 + 1), rx_reset_count)
    stuck = 0;
    run(0);
    c0 = rx_reset_count;
    run(1);
    `CHK("l2_clean", c0, rx_reset_count)
    stuck = 1;
    k = dsc_n;
    run(2);
    `CHK("l2_exit_rst", 8'(c0 + 1), rx_reset_count)
    `CHK("l2_exit_dsc", k + 1, dsc_n)
    stuck = 0;
    partner_gen2 = 0;
    {k, r0} = {dsc_n, n_rd};
    run(0);
    `CHK("no_gen2_dsc", k, dsc_n)
    `CHK("no_gen2_rd", r0, n_rd)
    `CHK("no_gen2_sup", 1'b0, gen2_support)
    `CHK("err_pulses", int'(rx_reset_count), err_n)
    // ==========================================
    // replay, ts2, low power, phystatus, sticky bit
    replay_num = 2'h2;
    step(1);
    replay_num = 2'h3;
    step(3);
    `CHK("no_wrap", 0, rq_n)
    replay_num = 2'h0;
    step(6);
    `CHK("wrap_req", 1, rq_n)
    `CHK("wrap_hold", 1'b1, replay_hold)
    retrain_done = 1;
    step(1);
    retrain_done = 0;
    step(2);
    `CHK("hold_free", 1'b0, replay_hold)
    in_rcvr_cfg = 1;
    ts2_sent = 1;
    step(31);
    ts2_sent = 0;
    step(1);
    `CHK("ts2_31", 1'b0, speed_ok)
    ts2_sent = 1;
    step(1);
    ts2_sent = 0;
    step(1);
    `CHK("ts2_32", 1'b1, speed_ok)
    in_rcvr_cfg = 0;
    for (i = 0; i < 5; i++) begin
      n = (i == 0) ? 1 : (i == 1) ? 255 : (i == 2) ? 2 : int'(rnd() & 8'hff);
      lp_entry_count = 8'(n);
      pm_cfg_write = 1;
      step(1);
      pm_cfg_write = 0;
      for (k = 1; k < 300 && lp_entry_go !== 1'b1; k++) step(1);
      `CHK("lp_delay", lp_expect(n), k)
    end
    p0_requested = 1;
    step(2);
    phystatus = 1;
    step(1);
    phystatus = 0;
    step(30);
    `CHK("phy_seen", 1'b1, phystatus_seen)
    `CHK("no_tmo", 1'b0, pwr_timeout_detect)
    p0_requested = 0;
    step(2);
    p0_requested = 1;
    // timeout flag rises on the edge after the counter reaches the limit
    step(20);
    `CHK("tmo_early", 1'b0, pwr_timeout_detect)
    step(1);
    `CHK("tmo_detect", 1'b1, pwr_timeout_detect)
    p0_requested = 0;
    for (i = 1; i >= 0; i--) begin
      {asd_wr, asd_wdata} = {1'b1, i[0]};
      step(1);
      asd_wr = 0;
      link_down_reset = 1;
      step(3);
      link_down_reset = 0;
      step(1);
      `CHK("asd_sticky", i[0], asd_bit)
    end
    // six sequences above end without a receiver reset
    `CHK("done_pulses", 6, done_n)
    close_out();
  end
endmodule
